// ### core/port_pin_override_mux.sv
// One 8-bit I/O port with alternate-function overrides and an AHB-Lite slave
//
// Summary of operation
// - Power-down, power-save and standby sleep clamp digital inputs to ground
// - External interrupt pins bypass clamp when enabled
// - Held-high edge pin with its interrupt disabled sets flag on wake
// - Pull-up override, else dir/out/off equals 010
// - Direction override, else direction bit drives
// - Driven value from override or output bit
// - Toggle override inverts output bit
// - Input enable override, else sleep state decides
// - Alternate input tapped before synchroniser
// - Strobes per port, sleep/pull-off shared
// - Peripherals supply per-pin override pairs
// - Pull-up disable bit kills all pull-ups except those set by a pull-up override
// - Control register layout, read-only zeros, reset zero
// - SPI clock, MOSI, MISO on bits 7,1,0
// - Bits 5 and 2 carry external interrupts
// - Direction one output, zero input
// - Writing pin input bit toggles output bit
// - Reset tri-states all pins
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
module port_pin_override_mux #(
   parameter int PINS = 8
) (
   // Clock and reset
   input  wire logic                                   clk_sys,
   input  wire logic                                   rst_n,
   // AHB-Lite slave
   input  wire logic                                   hsel,
   input  wire logic [31:0]                            haddr,
   input  wire logic [1:0]                             htrans,
   input  wire logic                                   hwrite,
   input  wire logic [2:0]                             hsize,
   input  wire logic [31:0]                            hwdata,
   input  wire logic                                   hready,
   output logic      [31:0]                            hrdata,
   output logic                                        hreadyout,
   output logic                                        hresp,
   // peripheral overrides, one bundle per pin
   input  wire pin_mux_pkg::pin_override_t [PINS-1:0]  pin_override,
   // External interrupt enables and sense from the interrupt unit
   input  wire logic                                   ext_irq_one_en,
   input  wire logic                                   ext_irq_two_en,
   input  wire pin_mux_pkg::ext_sense_t                ext_irq_one_sense,
   input  wire pin_mux_pkg::ext_sense_t                ext_irq_two_sense,
   // Pads
   input  wire logic [PINS-1:0]                        pad_in,
   output logic      [PINS-1:0]                        pad_out,
   output logic      [PINS-1:0]                        pad_oe,
   output logic      [PINS-1:0]                        pad_pullup,
   // Alternate digital inputs and named port B functions
   output logic      [PINS-1:0]                        alt_digital_in,
   output logic                                        spi_sck_in,
   output logic                                        spi_mosi_in,
   output logic                                        spi_miso_in,
   output logic                                        ext_irq_one,
   output logic                                        ext_irq_two,
   output logic      [PINS-1:0]                        pin_change_src,
   // Control bits for other blocks
   output logic                                        spi_pin_remap,
   output logic                                        vector_table_select,
   output logic                                        vector_change_unlock,
   // Interrupt
   output logic                                        irq
);
   // Register file
   logic [7:0]      mcu_control_reg;   // Control bits
   logic [PINS-1:0] dir_bit_reg;       // Direction, one is output
   logic [PINS-1:0] out_bit_reg;       // Output / pull-up select
   logic [PINS-1:0] sync_a_reg;        // Pin synchroniser first stage
   logic [PINS-1:0] pin_in_bit_reg;    // Synchronised pin value
   logic [1:0]      irq_status_reg;    // Sticky events
   logic [1:0]      irq_mask_reg;      // Event mask
   logic [2:0]      sleep_ctrl_reg;    // Sleep mode code
   logic            clamp_prev_reg;    // Clamp state last cycle
   logic [PINS-1:0] raw_a_reg;         // Unclamped pad sync, first stage
   logic [PINS-1:0] raw_b_reg;         // Unclamped pad sync, second stage
   // Bus pipeline
   logic            wr_pend_reg;
   logic [7:0]      addr_reg;
   logic [31:0]     hrdata_reg;
   logic            hreadyout_reg;     // Always ready
   logic            hresp_reg;         // Always OKAY
   // Pad outputs
   logic [PINS-1:0] pad_out_reg, pad_oe_reg, pad_pullup_reg, alt_in_reg;
   logic            irq_reg;
   // Combinational pad control
   pin_mux_pkg::pad_ctrl_t [PINS-1:0] pad_next;
   logic [PINS-1:0] toggle_next;
   logic [PINS-1:0] schmitt_out;
   logic            sleep_clamp;
   logic [1:0]      event_next;
   logic            addr_phase;
   logic            pad_in_hi_one;     // Held-high pin, interrupt one
   logic            pad_in_hi_two;     // Held-high pin, interrupt two
   logic            status_rd;         // Status read in address phase

   // Clamping sleep modes; idle and noise reduction keep inputs live
   function automatic logic clamp_mode(input logic [2:0] ctl);
      clamp_mode = (ctl == pin_mux_pkg::SLP_POWERDOWN) ||
                   (ctl == pin_mux_pkg::SLP_POWERSAVE) ||
                   (ctl == pin_mux_pkg::SLP_STANDBY);
   endfunction : clamp_mode

   // Edge-sensing configurations only
   function automatic logic edge_sense(input pin_mux_pkg::ext_sense_t s);
      edge_sense = (s != pin_mux_pkg::SENSE_LOW);
   endfunction : edge_sense

   // one sleep and pull-off shared by all pins
   assign sleep_clamp = clamp_mode(sleep_ctrl_reg);
   assign addr_phase  = hsel && hready && htrans[1];

   // Per-pin override muxing, purely combinational
   always_comb begin
      logic clamp_here;
      clamp_here = 1'b0;
      for (int n = 0; n < PINS; n++) begin
         // external interrupt pins skip clamp when enabled
         clamp_here = sleep_clamp;
         if (n == pin_mux_pkg::PIN_EXT_ONE && ext_irq_one_en) begin
            clamp_here = 1'b0;
         end
         if (n == pin_mux_pkg::PIN_EXT_TWO && ext_irq_two_en) begin
            clamp_here = 1'b0;
         end
         // overrides act in the same cycle
         if (pin_override[n].pullup_override_en) begin
            pad_next[n].pullup_en = pin_override[n].pullup_override_val;
         end else begin
            pad_next[n].pullup_en = ({dir_bit_reg[n], out_bit_reg[n],
               mcu_control_reg[pin_mux_pkg::BIT_PULLUP_OFF]} == 3'b010);
         end
         if (pin_override[n].dir_override_en) begin
            pad_next[n].drive_en = pin_override[n].dir_override_val;
         end else begin
            pad_next[n].drive_en = dir_bit_reg[n];
         end
         if (pin_override[n].value_override_en) begin
            pad_next[n].drive_val = pin_override[n].value_override_val;
         end else begin
            pad_next[n].drive_val = out_bit_reg[n];
         end
         // input enable override or sleep state
         if (pin_override[n].input_en_override_en) begin
            pad_next[n].input_en = pin_override[n].input_en_override_val;
         end else begin
            pad_next[n].input_en = !clamp_here;
         end
         // clamp to ground at schmitt input
         schmitt_out[n] = pad_in[n] & pad_next[n].input_en;
      end
   end

   // Bus address phase capture; one wait-free data phase follows
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= addr_phase && hwrite;
         addr_reg    <= haddr[7:0];
      end
   end

   // Control register, only the defined bits store
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mcu_control_reg <= pin_mux_pkg::MCU_CONTROL_RST;
         sleep_ctrl_reg  <= 3'b000;
         irq_mask_reg    <= 2'b00;
      end else if (wr_pend_reg) begin
         case (addr_reg)
            pin_mux_pkg::OFS_MCU_CONTROL: begin
               mcu_control_reg <= hwdata[7:0] & pin_mux_pkg::MCU_CONTROL_WMASK;
            end
            pin_mux_pkg::OFS_SLEEP_CTRL: begin
               sleep_ctrl_reg <= hwdata[2:0];
            end
            pin_mux_pkg::OFS_IRQ_MASK: begin
               irq_mask_reg <= hwdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Direction and output bits, with toggles
   always_comb begin
      for (int n = 0; n < PINS; n++) begin
         toggle_next[n] = pin_override[n].toggle_override_en;
      end
      // writing one to pin input toggles output
      if (wr_pend_reg && addr_reg == pin_mux_pkg::OFS_PIN_IN) begin
         toggle_next = toggle_next ^ hwdata[PINS-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dir_bit_reg <= pin_mux_pkg::PORT_RST[PINS-1:0];
         out_bit_reg <= pin_mux_pkg::PORT_RST[PINS-1:0];
      end else begin
         if (wr_pend_reg && addr_reg == pin_mux_pkg::OFS_DIR) begin
            dir_bit_reg <= hwdata[PINS-1:0];
         end
         // one write strobe for the whole port
         if (wr_pend_reg && addr_reg == pin_mux_pkg::OFS_OUT) begin
            out_bit_reg <= hwdata[PINS-1:0] ^ toggle_next;
         end else begin
            out_bit_reg <= out_bit_reg ^ toggle_next;
         end
      end
   end

   // Pin synchroniser for register reads
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync_a_reg     <= '0;
         pin_in_bit_reg <= '0;
      end else begin
         sync_a_reg     <= schmitt_out;
         pin_in_bit_reg <= sync_a_reg;
      end
   end

   // Wake detection and event flags
   always_comb begin
      event_next = 2'b00;
      // leaving clamp sets flag of held-high disabled edge pin
      if (clamp_prev_reg && !sleep_clamp) begin
         event_next[pin_mux_pkg::IRQ_BIT_ONE] = !ext_irq_one_en &&
            edge_sense(ext_irq_one_sense) && pad_in_hi_one;
         event_next[pin_mux_pkg::IRQ_BIT_TWO] = !ext_irq_two_en &&
            edge_sense(ext_irq_two_sense) && pad_in_hi_two;
      end
   end

   // Unclamped pad synchroniser and clamp history for the wake check;
   // the clamped path would hide a pin held high through sleep
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         raw_a_reg      <= '0;
         raw_b_reg      <= '0;
         clamp_prev_reg <= 1'b0;
      end else begin
         raw_a_reg      <= pad_in;
         raw_b_reg      <= raw_a_reg;
         clamp_prev_reg <= sleep_clamp;
      end
   end

   // Only the second stage is read; status clears in its read's address phase
   assign pad_in_hi_one = raw_b_reg[pin_mux_pkg::PIN_EXT_ONE];
   assign pad_in_hi_two = raw_b_reg[pin_mux_pkg::PIN_EXT_TWO];
   assign status_rd     = addr_phase && !hwrite &&
                          (haddr[7:0] == pin_mux_pkg::OFS_IRQ_STATUS);

   // Sticky flags; an event in the clearing cycle still lands
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_status_reg <= 2'b00;
      end else if (status_rd) begin
         irq_status_reg <= event_next;
      end else begin
         irq_status_reg <= irq_status_reg | event_next;
      end
   end

   // Level interrupt, one cycle behind the flags
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // Read word for a byte offset; unmapped places read zero
   function automatic logic [31:0] read_word(input logic [7:0] a);
      case (a)
         pin_mux_pkg::OFS_MCU_CONTROL: read_word = {24'h0, mcu_control_reg};
         pin_mux_pkg::OFS_DIR:         read_word = 32'(dir_bit_reg);
         pin_mux_pkg::OFS_OUT:         read_word = 32'(out_bit_reg);
         pin_mux_pkg::OFS_PIN_IN:      read_word = 32'(pin_in_bit_reg);
         pin_mux_pkg::OFS_IRQ_STATUS:  read_word = {30'h0, irq_status_reg};
         pin_mux_pkg::OFS_IRQ_MASK:    read_word = {30'h0, irq_mask_reg};
         pin_mux_pkg::OFS_SLEEP_CTRL:  read_word = {29'h0, sleep_ctrl_reg};
         default:                      read_word = 32'h0;
      endcase
   endfunction : read_word

   // Read data loaded at the address edge so it stands in the data phase
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hrdata_reg    <= 32'h0;
         hreadyout_reg <= 1'b1;
         hresp_reg     <= 1'b0;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg     <= 1'b0;
         if (addr_phase && !hwrite) begin
            hrdata_reg <= read_word(haddr[7:0]);
         end
      end
   end

   // reset leaves every pin undriven; flops cost one cycle of latency
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pad_out_reg    <= '0;
         pad_oe_reg     <= '0;
         pad_pullup_reg <= '0;
         alt_in_reg     <= '0;
      end else begin
         for (int n = 0; n < PINS; n++) begin
            pad_out_reg[n]    <= pad_next[n].drive_val;
            pad_oe_reg[n]     <= pad_next[n].drive_en;
            pad_pullup_reg[n] <= pad_next[n].pullup_en;
         end
         // alternate input taken ahead of the synchroniser
         alt_in_reg <= schmitt_out;
      end
   end

   // Bus and pad outputs straight from their flops
   assign hrdata         = hrdata_reg;
   assign hreadyout      = hreadyout_reg;
   assign hresp          = hresp_reg;
   assign pad_out        = pad_out_reg;
   assign pad_oe         = pad_oe_reg;
   assign pad_pullup     = pad_pullup_reg;
   assign alt_digital_in = alt_in_reg;
   assign irq            = irq_reg;
   // SPI lines on bits 7, 1, 0; pin-change by index
   assign spi_sck_in     = alt_in_reg[pin_mux_pkg::PIN_SPI_SCK];
   assign spi_mosi_in    = alt_in_reg[pin_mux_pkg::PIN_SPI_MOSI];
   assign spi_miso_in    = alt_in_reg[pin_mux_pkg::PIN_SPI_MISO];
   assign pin_change_src = alt_in_reg;
   assign ext_irq_one    = alt_in_reg[pin_mux_pkg::PIN_EXT_ONE];
   assign ext_irq_two    = alt_in_reg[pin_mux_pkg::PIN_EXT_TWO];
   assign spi_pin_remap        = mcu_control_reg[pin_mux_pkg::BIT_SPI_REMAP];
   assign vector_table_select  = mcu_control_reg[pin_mux_pkg::BIT_VECTOR_SEL];
   assign vector_change_unlock = mcu_control_reg[pin_mux_pkg::BIT_VECTOR_UNLK];
endmodule : port_pin_override_mux

// ### core/pin_mux_pkg.sv
// Package for the port pin override multiplexer: offsets, fields, carriers
package pin_mux_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_MCU_CONTROL = 8'h00;
   localparam logic [7:0] OFS_DIR         = 8'h04;
   localparam logic [7:0] OFS_OUT         = 8'h08;
   localparam logic [7:0] OFS_PIN_IN      = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
   localparam logic [7:0] OFS_SLEEP_CTRL  = 8'h18;
   // Field positions in mcu_control
   localparam int BIT_SPI_REMAP    = 7;
   localparam int BIT_PULLUP_OFF   = 4;
   localparam int BIT_VECTOR_SEL   = 1;
   localparam int BIT_VECTOR_UNLK  = 0;
   // Writable bits of mcu_control; others read zero
   localparam logic [7:0] MCU_CONTROL_WMASK = 8'h93;
   // Reset values
   localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
   localparam logic [7:0] PORT_RST        = 8'h00;
   // Pin positions of port B
   localparam int PIN_SPI_SCK   = 7;
   localparam int PIN_EXT_TWO   = 5;
   localparam int PIN_EXT_ONE   = 2;
   localparam int PIN_SPI_MOSI  = 1;
   localparam int PIN_SPI_MISO  = 0;
   // Interrupt status bit positions
   localparam int IRQ_BIT_ONE = 0;
   localparam int IRQ_BIT_TWO = 1;
   // Sleep modes
   typedef enum logic [2:0] {
      SLP_IDLE      = 3'b000,
      SLP_NOISE     = 3'b001,
      SLP_POWERDOWN = 3'b010,
      SLP_POWERSAVE = 3'b011,
      SLP_STANDBY   = 3'b110
   } sleep_mode_t;
   // Per-pin override bundle from a peripheral
   typedef struct packed {
      logic pullup_override_en;
      logic pullup_override_val;
      logic dir_override_en;
      logic dir_override_val;
      logic value_override_en;
      logic value_override_val;
      logic toggle_override_en;
      logic input_en_override_en;
      logic input_en_override_val;
   } pin_override_t;
   // Per-pin pad control
   typedef struct packed {
      logic drive_en;
      logic drive_val;
      logic pullup_en;
      logic input_en;
   } pad_ctrl_t;
   // External interrupt sense settings: low level or an edge
   typedef enum logic [1:0] {
      SENSE_LOW  = 2'b00,
      SENSE_ANY  = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_RISE = 2'b11
   } ext_sense_t;
endpackage : pin_mux_pkg

// ### sim/port_pin_override_mux_props.sv
// Port-level assertions for the port pin override multiplexer
`timescale 1ns/10ps
module port_pin_override_mux_props #(
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic                                  clk_sys,
   input wire logic                                  rst_n,
   // Overrides and pads
   input wire pin_mux_pkg::pin_override_t [PINS-1:0] pin_override,
   input wire logic [PINS-1:0]                       pad_in,
   input wire logic [PINS-1:0]                       pad_out,
   input wire logic [PINS-1:0]                       pad_oe,
   input wire logic [PINS-1:0]                       pad_pullup,
   input wire logic [PINS-1:0]                       alt_digital_in,
   // Control bits
   input wire logic                                  spi_pin_remap,
   input wire logic                                  vector_table_select,
   input wire logic                                  vector_change_unlock
);
   logic [PINS-1:0] pu_en, pu_val, dd_en, dd_val, pv_en, pv_val, ie_en, ie_val; // Field slices
   // Gather override fields as vectors so one check covers every pin
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         pu_en[i]  = pin_override[i].pullup_override_en;
         pu_val[i] = pin_override[i].pullup_override_val;
         dd_en[i]  = pin_override[i].dir_override_en;
         dd_val[i] = pin_override[i].dir_override_val;
         pv_en[i]  = pin_override[i].value_override_en;
         pv_val[i] = pin_override[i].value_override_val;
         ie_en[i]  = pin_override[i].input_en_override_en;
         ie_val[i] = pin_override[i].input_en_override_val;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Pads and alternate inputs are registered: overrides show one edge later
   property p_pullup_ovr; ((pad_pullup ^ $past(pu_val)) & $past(pu_en)) == '0; endproperty
   a_pullup_ovr: assert property (p_pullup_ovr) else $error("pull-up ignores override");
   property p_pullup_out; (pad_pullup & pad_oe & ~$past(pu_en | dd_en)) == '0; endproperty
   a_pullup_out: assert property (p_pullup_out) else $error("pull-up on driven pin");
   property p_dir_ovr; ((pad_oe ^ $past(dd_val)) & $past(dd_en)) == '0; endproperty
   a_dir_ovr: assert property (p_dir_ovr) else $error("driver ignores override");
   property p_val_ovr; ((pad_out ^ $past(pv_val)) & $past(pv_en) & pad_oe) == '0; endproperty
   a_val_ovr: assert property (p_val_ovr) else $error("value ignores override");
   property p_input_off; (alt_digital_in & $past(ie_en & ~ie_val)) == '0; endproperty
   a_input_off: assert property (p_input_off) else $error("disabled input not low");
   property p_alt_tap;
      ((alt_digital_in ^ $past(pad_in)) & $past(ie_en & ie_val)) == '0;
   endproperty
   a_alt_tap: assert property (p_alt_tap) else $error("alternate input delayed");
   property p_reset_tri; $rose(rst_n) && dd_en == '0 |-> pad_oe == '0; endproperty
   a_reset_tri: assert property (p_reset_tri) else $error("pins driven after reset");
   property p_ctrl_zero;
      $rose(rst_n) |-> !(spi_pin_remap | vector_table_select | vector_change_unlock);
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("control bits not cleared");
endmodule : port_pin_override_mux_props

bind port_pin_override_mux port_pin_override_mux_props #(.PINS(PINS)) u_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .pin_override(pin_override), .pad_in(pad_in),
   .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
   .alt_digital_in(alt_digital_in), .spi_pin_remap(spi_pin_remap),
   .vector_table_select(vector_table_select), .vector_change_unlock(vector_change_unlock));

// ### sim/pad_model.sv
// Pad-side model: external drivers, pull-ups and floating pins
`timescale 1ns/10ps
module pad_model (
   // Clock
   input  wire logic       clk_sys,
   // Pad side of the port
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pad_pullup,
   // External drivers set by the bench
   input  wire logic [7:0] ext_drv,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pad_in
);
   logic [7:0] float_reg = 8'h55; // Undriven pins wander so no level is trusted
   // Floating pattern flips every cycle
   always @(posedge clk_sys) float_reg <= ~float_reg;
   // Port driver wins, then external driver, then pull-up
   always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
                      | (~pad_oe & ~ext_drv & (pad_pullup | float_reg));
endmodule : pad_model

// ### sim/port_pin_override_mux_tb.sv
// Self-checking bench for the port pin override multiplexer
`timescale 1ns/10ps
module port_pin_override_mux_tb;
   logic clk_sys = 1'b0;                        // 50 MHz clock
   logic rst_n = 1'b0;                          // Synchronous reset
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd; // Bus data
   logic [1:0] htrans = 2'b00;                  // Bus transfer kind
   logic hwrite = 1'b0, hreadyout, hresp, irq;  // Bus control
   pin_mux_pkg::pin_override_t [7:0] ovr = '0;  // Peripheral overrides
   logic [2:0] ctl_bits, spi;                   // Control and SPI outputs
   logic [1:0] xi;                              // External interrupt inputs
   logic [7:0] chg;                             // Pin-change sources
   logic one_en = 1'b0, two_en = 1'b0;          // External interrupt enables
   pin_mux_pkg::ext_sense_t one_sense = pin_mux_pkg::SENSE_RISE;
   pin_mux_pkg::ext_sense_t two_sense = pin_mux_pkg::SENSE_RISE;
   logic [7:0] ext_drv = '0, ext_val = '0, pad_in, pad_out, pad_oe, pad_pullup, alt_in;
   int num_errors = 0, num_checks = 0;
   always #10 clk_sys = ~clk_sys;
   port_pin_override_mux #(.PINS(8)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pin_override(ovr), .ext_irq_one_en(one_en), .ext_irq_two_en(two_en),
      .ext_irq_one_sense(one_sense), .ext_irq_two_sense(two_sense), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .alt_digital_in(alt_in),
      .spi_sck_in(spi[2]), .spi_mosi_in(spi[1]), .spi_miso_in(spi[0]),
      .ext_irq_one(xi[0]), .ext_irq_two(xi[1]), .pin_change_src(chg),
      .spi_pin_remap(ctl_bits[2]), .vector_table_select(ctl_bits[1]),
      .vector_change_unlock(ctl_bits[0]), .irq(irq));
   pad_model pads (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in));
   // Verdict and stop
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Compare seen against expected
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Wait for ready under a bound; a hang ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin num_errors++; end_of_test(); end
   endtask : wait_rdy
   // One single-word transfer; ends just after the data edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a}; hwrite <= wr; htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00; hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
      #1;
   endtask : xfer
   // Let registered pad outputs follow, then look
   task automatic settle();
      @(posedge clk_sys);
      #1;
   endtask : settle
   // Control register reset, masking, unmapped place
   task automatic t_regs();
      xfer(1'b0, pin_mux_pkg::OFS_MCU_CONTROL, '0);
      chk("ctrl reset", rd, 32'h0);
      xfer(1'b1, pin_mux_pkg::OFS_MCU_CONTROL, 32'hffffffff);
      xfer(1'b0, pin_mux_pkg::OFS_MCU_CONTROL, '0);
      chk("ctrl ro bits", rd, 32'h93);
      chk("ctrl outs", ctl_bits, 3'b111);
      xfer(1'b1, pin_mux_pkg::OFS_MCU_CONTROL, 32'h0);
      xfer(1'b1, 8'h40, 32'hffffffff);
      xfer(1'b0, 8'h40, '0);
      chk("unmapped", rd, 32'h0);
      $display("t_regs done");
   endtask : t_regs
   // Direction, output, pull-up, toggle, global pull-up off
   task automatic t_port();
      xfer(1'b1, pin_mux_pkg::OFS_DIR, 32'h0f);
      xfer(1'b1, pin_mux_pkg::OFS_OUT, 32'h5a);
      settle();
      chk("oe", pad_oe, 8'h0f);
      chk("out", pad_out & pad_oe, 8'h0a);
      chk("pullup", pad_pullup, 8'h50);
      xfer(1'b1, pin_mux_pkg::OFS_PIN_IN, 32'h03);
      settle();
      chk("toggle", pad_out & pad_oe, 8'h09);
      xfer(1'b1, pin_mux_pkg::OFS_MCU_CONTROL, 32'h10);
      settle();
      chk("pullup off", pad_pullup, 8'h00);
      xfer(1'b1, pin_mux_pkg::OFS_MCU_CONTROL, 32'h0);
      $display("t_port done");
   endtask : t_port
   // Peripheral overrides show at the registered pads one edge later
   task automatic t_over();
      ovr[3] <= 9'b111000000;
      ovr[6] <= 9'b001110000;
      ovr[4] <= 9'b000000010;
      ovr[5] <= 9'b000000011;
      settle();
      chk("pu ovr", pad_pullup[3], 1'b1);
      chk("dd off", pad_oe[3], 1'b0);
      chk("dd on", pad_oe[6], 1'b1);
      chk("pv ovr", pad_out[6], 1'b0);
      chk("ie off", alt_in[4], 1'b0);
      @(posedge clk_sys);
      ovr <= '0;
      #1;
      ovr[0] <= 9'h004;
      @(posedge clk_sys);
      ovr[0] <= '0;
      settle();
      chk("toggle_override_en", pad_out[0], 1'b0);
      $display("t_over done");
   endtask : t_over
   // Sleep clamp, interrupt bypass, wake flag, mask and clear
   task automatic t_sleep();
      xfer(1'b1, pin_mux_pkg::OFS_DIR, 32'h0);
      ext_drv <= 8'hb7; ext_val <= 8'h34; one_en <= 1'b1;
      repeat (4) @(posedge clk_sys);
      xfer(1'b0, pin_mux_pkg::OFS_IRQ_STATUS, '0);
      xfer(1'b1, pin_mux_pkg::OFS_SLEEP_CTRL, {29'h0, pin_mux_pkg::SLP_POWERDOWN});
      settle();
      chk("clamp", alt_in[4], 1'b0);
      chk("bypass", alt_in[2], 1'b1);
      xfer(1'b1, pin_mux_pkg::OFS_SLEEP_CTRL, {29'h0, pin_mux_pkg::SLP_IDLE});
      settle();
      chk("awake", alt_in[4], 1'b1);
      chk("ext irq in", xi, 2'b11);
      chk("spi in", spi, 3'b000);
      chk("pin change", chg & 8'hb7, 8'h34);
      repeat (4) @(posedge clk_sys);
      #1;
      chk("masked", irq, 1'b0);
      xfer(1'b1, pin_mux_pkg::OFS_IRQ_MASK, 32'h2);
      settle();
      chk("irq", irq, 1'b1);
      xfer(1'b0, pin_mux_pkg::OFS_IRQ_STATUS, '0);
      chk("wake flag", rd & 32'h2, 32'h2);
      chk("enabled no flag", rd & 32'h1, 32'h0);
      chk("cleared", irq, 1'b0);
      $display("t_sleep done");
   endtask : t_sleep
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_port();
      t_over();
      t_sleep();
      end_of_test();
   end
endmodule : port_pin_override_mux_tb
